// [pkg/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

  // Register indices; each register sits at byte address four times its index.
  localparam logic [11:0] RESULT_IDX     = 12'h0D0;
  localparam logic [11:0] CONTROL_IDX    = 12'h0D1;
  localparam logic [11:0] RESULT_ADDR    = {RESULT_IDX[9:0], 2'b00};
  localparam logic [11:0] CONTROL_ADDR   = {CONTROL_IDX[9:0], 2'b00};

  localparam int          IRQ_EN_BIT     = 7;
  localparam int          DONE_BIT       = 6;
  localparam int          START_BIT      = 5;
  localparam int          POWER_BIT      = 4;

  localparam logic [7:0]  CONTROL_RESET  = 8'h40;
  localparam logic [7:0]  RESULT_RESET   = 8'h00;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          SAMPLE_TIME_NS = 1000;
  localparam int          STEP_TIME_NS   = 8000;
  localparam int          SAMPLE_CYCLES  = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STEP_CYCLES    = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TIMER_W        = 8;

  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'h1,
    SEQ_SAMPLE  = 3'h2,
    SEQ_RESOLVE = 3'h4
  } seq_state_t;

endpackage : adc_ctrl_pkg

// [logic/step_timer.sv]
`timescale 1ns/1ps
module step_timer #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         clear,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic [W-1:0] reload;

  // Counts period cycles, restarting from a full period after clear.
  assign reload     = period - W'(1);
  assign count_next = (clear || count_reg == '0) ? reload : count_reg - W'(1);
  assign tick       = !clear && count_reg == '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : step_timer

// [logic/sar_register.sv]
`timescale 1ns/1ps
module sar_register #(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             load,
  input  wire logic             step,
  input  wire logic             comparator_high,
  output logic [WIDTH-1:0]      trial_code,
  output logic [WIDTH-1:0]      code_next,
  output logic                  last_step
);

  logic [WIDTH-1:0] code_reg;
  logic [WIDTH:0]   mask_reg;
  logic [WIDTH:0]   mask_next;

  // The bit under trial keeps the comparator answer; the next lower bit becomes the new trial.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign code_next[i] = mask_reg[i] ? comparator_high
                        : (mask_reg[i+1] ? 1'b1 : code_reg[i]);
  end

  assign mask_next  = {1'b0, mask_reg[WIDTH:1]};
  assign last_step  = step && mask_reg[0];
  assign trial_code = code_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_reg <= '0;
      mask_reg <= '0;
    end else if (load) begin
      code_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      mask_reg <= {2'b01, {(WIDTH-1){1'b0}}};
    end else if (step) begin
      code_reg <= code_next;
      mask_reg <= mask_next;
    end
  end

endmodule : sar_register

// [logic/sar_adc_control_sequencer.sv]
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module sar_adc_control_sequencer #(
  parameter int RESULT_W = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [11:0]         awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [11:0]         araddr,
  input  wire logic [2:0]          arprot,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                wait_mode,
  input  wire logic                stop_mode,
  input  wire logic                comparator_high,
  output logic                     converter_power_on,
  output logic                     sample_enable,
  output logic [RESULT_W-1:0]      trial_code,
  output logic                     conversion_irq,
  output logic                     wake_request
);

  // Write channel holding registers.
  logic                awready_reg;
  logic                wready_reg;
  logic                aw_full_reg;
  logic                w_full_reg;
  logic [11:0]         aw_addr_reg;
  logic [7:0]          w_data_reg;
  logic                w_strb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;

  // Read channel registers.
  logic                arready_reg;
  logic                rvalid_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;

  // Control and status state.
  logic                irq_enable_reg;
  logic                power_reg;
  logic                done_reg;
  logic [RESULT_W-1:0] result_reg;
  logic                irq_reg;
  logic                wake_reg;
  logic                power_out_reg;
  logic                sample_reg;

  adc_ctrl_pkg::seq_state_t state_reg;
  adc_ctrl_pkg::seq_state_t state_next;

  // Bus decode wires.
  logic                aw_take;
  logic                w_take;
  logic                aw_full_next;
  logic                w_full_next;
  logic                wr_fire;
  logic                wr_ctrl_hit;
  logic                wr_result_hit;
  logic                wr_mapped;
  logic                wr_ctrl_byte;
  logic                bvalid_next;
  logic                ar_take;
  logic                rvalid_next;
  logic                rd_ctrl_hit;
  logic                rd_result_hit;
  logic [7:0]          ctrl_view;
  logic [31:0]         rd_word;

  // Sequencer wires.
  logic                start_write;
  logic                can_run;
  logic                abort;
  logic                begin_conv;
  logic                tick;
  logic                sar_load;
  logic                sar_step;
  logic                sar_last;
  logic                finish;
  logic                done_next;
  logic                irq_next;
  logic [RESULT_W-1:0] code_next;
  logic [adc_ctrl_pkg::TIMER_W-1:0] period;

  // Address and data are taken independently; a write executes once both are held.
  assign aw_take      = awvalid && awready_reg;
  assign w_take       = wvalid && wready_reg;
  assign wr_fire      = aw_full_reg && w_full_reg && !bvalid_reg;
  assign aw_full_next = (aw_full_reg || aw_take) && !wr_fire;
  assign w_full_next  = (w_full_reg || w_take) && !wr_fire;
  assign bvalid_next  = wr_fire || (bvalid_reg && !bready);

  assign wr_ctrl_hit   = aw_addr_reg == adc_ctrl_pkg::CONTROL_ADDR;
  assign wr_result_hit = aw_addr_reg == adc_ctrl_pkg::RESULT_ADDR;
  assign wr_mapped     = wr_ctrl_hit || wr_result_hit;
  assign wr_ctrl_byte  = wr_fire && wr_ctrl_hit && w_strb_reg;

  // The result register is read only, so a write there is accepted and ignored.
  assign start_write = wr_ctrl_byte && w_data_reg[adc_ctrl_pkg::START_BIT];

  assign ar_take       = arvalid && arready_reg;
  assign rvalid_next   = ar_take || (rvalid_reg && !rready);
  assign rd_ctrl_hit   = araddr == adc_ctrl_pkg::CONTROL_ADDR;
  assign rd_result_hit = araddr == adc_ctrl_pkg::RESULT_ADDR;

  // Start and reserved positions read as zero.
  assign ctrl_view = {irq_enable_reg, done_reg, 1'b0, power_reg, 4'h0};

  assign rd_word = rd_ctrl_hit   ? {24'h00_0000, ctrl_view}
                 : rd_result_hit ? {{(32-RESULT_W){1'b0}}, result_reg}
                 : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= !aw_full_next;
      wready_reg  <= !w_full_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= awaddr;
      end
      if (w_take) begin
        w_data_reg <= wdata[7:0];
        w_strb_reg <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= adc_ctrl_pkg::RESP_OKAY;
    end else begin
      bvalid_reg <= bvalid_next;
      if (wr_fire) begin
        bresp_reg <= wr_mapped ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= adc_ctrl_pkg::RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= (rd_ctrl_hit || rd_result_hit) ? adc_ctrl_pkg::RESP_OKAY
                                                    : adc_ctrl_pkg::RESP_SLVERR;
      end
    end
  end

  // Software writable control bits; the done flag is not writable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_reg <= adc_ctrl_pkg::CONTROL_RESET[adc_ctrl_pkg::IRQ_EN_BIT];
      power_reg      <= adc_ctrl_pkg::CONTROL_RESET[adc_ctrl_pkg::POWER_BIT];
    end else if (wr_ctrl_byte) begin
      irq_enable_reg <= w_data_reg[adc_ctrl_pkg::IRQ_EN_BIT];
      power_reg      <= w_data_reg[adc_ctrl_pkg::POWER_BIT];
    end
  end

  // A conversion runs only while powered and out of STOP; WAIT has no effect.
  assign can_run    = power_reg && !stop_mode;
  assign begin_conv = start_write && can_run;
  assign abort      = !can_run && state_reg != adc_ctrl_pkg::SEQ_IDLE;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      adc_ctrl_pkg::SEQ_IDLE: begin
        state_next = adc_ctrl_pkg::SEQ_IDLE;
      end
      adc_ctrl_pkg::SEQ_SAMPLE: begin
        if (tick) begin
          state_next = adc_ctrl_pkg::SEQ_RESOLVE;
        end
      end
      adc_ctrl_pkg::SEQ_RESOLVE: begin
        if (sar_last) begin
          state_next = adc_ctrl_pkg::SEQ_IDLE;
        end
      end
      default: begin
        state_next = adc_ctrl_pkg::SEQ_IDLE;
      end
    endcase
    if (abort) begin
      state_next = adc_ctrl_pkg::SEQ_IDLE;
    end
    if (begin_conv) begin
      state_next = adc_ctrl_pkg::SEQ_SAMPLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= adc_ctrl_pkg::SEQ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // The reload length follows the phase being entered, so the first bit trial gets a full step.
  assign period = (state_next == adc_ctrl_pkg::SEQ_RESOLVE)
                ? adc_ctrl_pkg::TIMER_W'(adc_ctrl_pkg::STEP_CYCLES)
                : adc_ctrl_pkg::TIMER_W'(adc_ctrl_pkg::SAMPLE_CYCLES);

  assign sar_load = state_reg == adc_ctrl_pkg::SEQ_SAMPLE && tick && !begin_conv && !abort;
  assign sar_step = state_reg == adc_ctrl_pkg::SEQ_RESOLVE && tick && !begin_conv && !abort;
  assign finish   = sar_last && !begin_conv && !abort;

  step_timer #(
    .W      (adc_ctrl_pkg::TIMER_W)
  ) u_step_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (begin_conv || abort || state_reg == adc_ctrl_pkg::SEQ_IDLE),
    .period  (period),
    .tick    (tick)
  );

  sar_register #(
    .WIDTH (RESULT_W)
  ) u_sar_register (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .load            (sar_load),
    .step            (sar_step),
    .comparator_high (comparator_high),
    .trial_code      (trial_code),
    .code_next       (code_next),
    .last_step       (sar_last)
  );

  // A start clears the flag even when it coincides with the end of the previous run.
  assign done_next = start_write ? 1'b0 : (finish ? 1'b1 : done_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg <= adc_ctrl_pkg::CONTROL_RESET[adc_ctrl_pkg::DONE_BIT];
    end else begin
      done_reg <= done_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= adc_ctrl_pkg::RESULT_RESET;
    end else if (finish) begin
      result_reg <= code_next;
    end
  end

  // The request stays up while the flag and the enable are both set.
  assign irq_next = done_next && irq_enable_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg  <= irq_next;
      wake_reg <= irq_next && wait_mode && !stop_mode;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_out_reg <= 1'b0;
      sample_reg    <= 1'b0;
    end else begin
      power_out_reg <= can_run;
      sample_reg    <= state_next == adc_ctrl_pkg::SEQ_SAMPLE;
    end
  end

  assign awready            = awready_reg;
  assign wready             = wready_reg;
  assign bvalid             = bvalid_reg;
  assign bresp              = bresp_reg;
  assign arready            = arready_reg;
  assign rvalid             = rvalid_reg;
  assign rdata              = rdata_reg;
  assign rresp              = rresp_reg;
  assign converter_power_on = power_out_reg;
  assign sample_enable      = sample_reg;
  assign conversion_irq     = irq_reg;
  assign wake_request       = wake_reg;

endmodule : sar_adc_control_sequencer

// [bench/analog_core_model.sv]
`timescale 1ns/1ps
module analog_core_model (
  input  wire logic       aclk,
  input  wire logic       converter_power_on,
  input  wire logic [7:0] trial_code,
  input  wire logic [8:0] level,
  output logic            comparator_high
);
  logic junk_reg = 1'b0;

  // An unpowered comparator gives no stable answer.
  always_ff @(posedge aclk) begin
    junk_reg <= ~junk_reg;
  end

  // A level of 9'h100 stands for an input above the top reference.
  assign comparator_high = converter_power_on ? ({1'b0, trial_code} <= level) : junk_reg;
endmodule : analog_core_model

// [bench/adc_seq_properties.sv]
`timescale 1ns/1ps
module adc_seq_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [11:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        converter_power_on,
  input wire logic        sample_enable,
  input wire logic        conversion_irq,
  input wire logic        wake_request
);
  logic [11:0] rd_addr_reg;
  logic [4:0]  samp_reg;
  logic [3:0]  since_reg;
  wire ctl_wr = awvalid && awready && wvalid && wready && wstrb[0]
                && awaddr == adc_ctrl_pkg::CONTROL_ADDR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_reg <= 12'h000;
      samp_reg    <= 5'h00;
      since_reg   <= 4'hf;
    end else begin
      if (arvalid && arready) rd_addr_reg <= araddr;
      samp_reg  <= sample_enable ? samp_reg + 5'h01 : 5'h00;
      since_reg <= (ctl_wr && wdata[5]) ? 4'h0 : (since_reg == 4'hf ? 4'hf : since_reg + 4'h1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_power_up;
    ctl_wr && wdata[4] ##1 (!stop_mode)[*3];
  endsequence
  sequence s_kick;
    ctl_wr && wdata[5] && converter_power_on ##1 !stop_mode;
  endsequence

  property p_enable_gate; ctl_wr && !wdata[7] |-> ##[1:3] !conversion_irq; endproperty
  property p_start_clear; ctl_wr && wdata[5] |-> ##[1:3] !conversion_irq; endproperty
  property p_power_off; ctl_wr && !wdata[4] |-> ##[1:3] !converter_power_on; endproperty
  property p_power_on; s_power_up |-> converter_power_on; endproperty
  property p_kick; s_kick |-> ##[0:2] sample_enable; endproperty
  property p_no_auto; $rose(sample_enable) |-> since_reg <= 4'h4; endproperty
  property p_samp_len;
    $fell(sample_enable) && converter_power_on |->
      samp_reg >= adc_ctrl_pkg::SAMPLE_CYCLES && samp_reg <= adc_ctrl_pkg::SAMPLE_CYCLES + 1;
  endproperty
  property p_stop; stop_mode |=> !converter_power_on; endproperty
  property p_wake;
    wake_request |-> conversion_irq && $past(wait_mode) && !$past(stop_mode);
  endproperty
  property p_start_zero;
    rvalid && rd_addr_reg == adc_ctrl_pkg::CONTROL_ADDR |-> !rdata[5];
  endproperty

  a_enable_gate: assert property (p_enable_gate) else $error("irq kept with enable clear");
  a_start_clear: assert property (p_start_clear) else $error("irq kept after start");
  a_power_off: assert property (p_power_off) else $error("converter stays on");
  a_power_on: assert property (p_power_on) else $error("converter not on");
  a_kick: assert property (p_kick) else $error("start did not sample");
  a_no_auto: assert property (p_no_auto) else $error("conversion without start");
  a_samp_len: assert property (p_samp_len) else $error("sampling length wrong");
  a_stop: assert property (p_stop) else $error("converter on in stop");
  a_wake: assert property (p_wake) else $error("wake without cause");
  a_start_zero: assert property (p_start_zero) else $error("start bit read as one");
endmodule : adc_seq_checker

bind sar_adc_control_sequencer adc_seq_checker chk (.aclk, .aresetn, .awaddr, .awvalid,
  .awready, .wdata, .wstrb, .wvalid, .wready, .araddr, .arvalid, .arready, .rdata, .rvalid,
  .wait_mode, .stop_mode, .converter_power_on, .sample_enable, .conversion_irq, .wake_request);

// [bench/sar_adc_control_sequencer_tb_top.sv]
`timescale 1ns/1ps
module sar_adc_control_sequencer_tb_top;
  localparam logic [11:0] CTL = adc_ctrl_pkg::CONTROL_ADDR;
  localparam logic [11:0] RES = adc_ctrl_pkg::RESULT_ADDR;
  localparam int          CONV = adc_ctrl_pkg::SAMPLE_CYCLES + 8 * adc_ctrl_pkg::STEP_CYCLES;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [2:0]  awprot = 3'h0;
  logic [2:0]  arprot = 3'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [8:0]  level = 9'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        wait_mode = 1'b0, stop_mode = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, comparator_high;
  wire         converter_power_on, sample_enable, conversion_irq, wake_request;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  trial_code;
  int          fail_count = 0, total_checks = 0, cyc = 0, t0;
  logic [31:0] v;
  logic [1:0]  resp;
  logic [8:0]  lv_tab [5] = '{9'h000, 9'h05A, 9'h05B, 9'h0A5, 9'h100};

  always #25 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  sar_adc_control_sequencer dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .wait_mode, .stop_mode, .comparator_high,
    .converter_power_on, .sample_enable, .trial_code, .conversion_irq, .wake_request);
  analog_core_model core (.aclk, .converter_power_on, .trial_code, .level, .comparator_high);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic conv(input logic [8:0] lvl, input logic [7:0] ctl);
    int n;
    n = 0;
    level <= lvl;
    wr(CTL, ctl);
    t0 = cyc;
    do begin
      rd(CTL, v);
      n++;
    end while (!v[6] && n < 1000);
    check(32'(cyc - t0 >= CONV && cyc - t0 <= CONV + 8), 32'h0000_0001);
    rd(RES, v);
    check(v, {24'h00_0000, lvl[8] ? 8'hff : lvl[7:0]});
  endtask : conv

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(RES, v);
    check(v, 32'h0000_0000);
    rd(CTL, v);
    check(v, 32'h0000_0040);
    rd(12'h348, v);
    check({v[31:2], resp}, {30'h0000_0000, adc_ctrl_pkg::RESP_SLVERR});
    wr(CTL, 8'h00);
    rd(CTL, v);
    check(v, 32'h0000_0040);
    wr(CTL, 8'h20);
    rd(CTL, v);
    check(v, 32'h0000_0000);
    wr(CTL, 8'h10);
    rd(CTL, v);
    check(v, 32'h0000_0010);
    check(32'(converter_power_on), 32'h0000_0001);
    foreach (lv_tab[i]) conv(lv_tab[i], 8'h30);
    repeat (1500) @(posedge aclk);
    check(32'(sample_enable), 32'h0000_0000);
    rd(CTL, v);
    check(v, 32'h0000_0050);
    level <= 9'h033;
    wr(CTL, 8'h30);
    repeat (500) @(posedge aclk);
    conv(9'h0C4, 8'h30);
    wait_mode <= 1'b1;
    conv(9'h0C4, 8'hB0);
    check(32'(conversion_irq), 32'h0000_0001);
    check(32'(wake_request), 32'h0000_0001);
    wr(CTL, 8'h10);
    repeat (3) @(posedge aclk);
    check(32'(conversion_irq), 32'h0000_0000);
    wr(CTL, 8'h90);
    repeat (3) @(posedge aclk);
    check(32'(conversion_irq), 32'h0000_0001);
    stop_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    check(32'(wake_request), 32'h0000_0000);
    stop_mode <= 1'b0;
    wr(CTL, 8'hB0);
    repeat (3) @(posedge aclk);
    check(32'(conversion_irq), 32'h0000_0000);
    repeat (400) @(posedge aclk);
    stop_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    check(32'(converter_power_on), 32'h0000_0000);
    repeat (1400) @(posedge aclk);
    stop_mode <= 1'b0;
    wait_mode <= 1'b0;
    rd(CTL, v);
    check(v, 32'h0000_0090);
    wr(CTL, 8'h30);
    repeat (400) @(posedge aclk);
    wr(CTL, 8'h00);
    repeat (3) @(posedge aclk);
    check(32'(converter_power_on), 32'h0000_0000);
    repeat (1400) @(posedge aclk);
    rd(CTL, v);
    check(v, 32'h0000_0000);
    wr(RES, 8'h55);
    check(32'(resp), 32'(adc_ctrl_pkg::RESP_OKAY));
    wr(12'h348, 8'h00);
    check(32'(resp), 32'(adc_ctrl_pkg::RESP_SLVERR));
    rd(RES, v);
    check(v, 32'h0000_00C4);
    wrap_up();
  end
endmodule : sar_adc_control_sequencer_tb_top
